// ### hw/output_clock_halt.sv
// Summary of operation
// - bits 3:2 halt config_output_5 low/high
// - bits 5:4 halt config_output_6 low/high
// - bits 7:6 halt config_output_7 low/high
// - gen2 bits 1:0 halt config_output_0
// - gen2 bits 3:2 halt config_output_1
// - gen2 bits 5:4 halt config_output_2
// - gen2 bits 7:6 halt config_output_3
// - gen0/1 bits 1:0 halt precision_output_0
// - gen0/1 bits 3:2 halt precision_output_1
// - gen0/1 bits 5:4 halt precision_output_2
// - gen0/1 bits 7:6 halt precision_output_3
// - One sticky lock-loss flag per synthesizer
// - Reset forces every lock-loss flag set
// - Clear bits 0-2 clear flags while high
// - Clear bit 3 clears synthesizer 3
// - gen3 bits 1:0 halt config_output_4
`timescale 1ns/1ps
`default_nettype none
`include "clock_halt_defs.svh"

module output_clock_halt
  import clock_halt_pkg::*;
#(
  parameter int NUM_OUT = 12,
  parameter int NUM_GEN = 4
) (
  input  wire logic               CLK_SYS,
  input  wire logic               RST,
  input  wire logic               CE,
  input  wire logic [7:0]         REG_ADDR,
  input  wire logic [7:0]         REG_WDATA,
  input  wire logic               REG_WR,
  output logic      [7:0]         REG_RDATA,
  input  wire logic [NUM_OUT-1:0] DIV_SRC,
  input  wire logic [NUM_GEN-1:0] LOCK_LOST,
  output logic      [7:0]         CONFIG_OUTPUT,
  output logic      [3:0]         PRECISION_OUTPUT
);

  generate
    if (NUM_OUT != 3 * `HALT_FIELDS_PER_REG || NUM_GEN != `LOCK_FLAG_W)
    begin : g_bad
      $error("Map is fixed at twelve outputs and four synthesizers");
    end
  endgenerate

  logic [7:0]         gen3_halt_r;
  logic [7:0]         gen3_halt_nxt;
  logic [7:0]         gen2_halt_r;
  logic [7:0]         gen2_halt_nxt;
  logic [7:0]         gen01_halt_r;
  logic [7:0]         gen01_halt_nxt;
  logic [7:0]         lock_clear_r;
  logic [7:0]         lock_clear_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic [NUM_GEN-1:0] lock_flags;
  halt_code_type      codes [NUM_OUT];
  logic [NUM_OUT-1:0] outs;

  // Register writes; status is read-only and ignores writes
  always_comb
  begin
    gen3_halt_nxt  = gen3_halt_r;
    gen2_halt_nxt  = gen2_halt_r;
    gen01_halt_nxt = gen01_halt_r;
    lock_clear_nxt = lock_clear_r;
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        `OFS_GEN3_HALT:  gen3_halt_nxt  = REG_WDATA;
        `OFS_GEN2_HALT:  gen2_halt_nxt  = REG_WDATA;
        `OFS_GEN01_HALT: gen01_halt_nxt = REG_WDATA;
        `OFS_LOCK_CLEAR: lock_clear_nxt = REG_WDATA;
        default:         ;
      endcase
    end
  end

  // Read data is registered; unmapped offsets read as zero
  always_comb
  begin
    unique case (REG_ADDR)
      `OFS_GEN3_HALT:   rdata_nxt = gen3_halt_r;
      `OFS_GEN2_HALT:   rdata_nxt = gen2_halt_r;
      `OFS_GEN01_HALT:  rdata_nxt = gen01_halt_r;
      `OFS_LOCK_STATUS: rdata_nxt = {4'h0, lock_flags};
      `OFS_LOCK_CLEAR:  rdata_nxt = lock_clear_r;
      default:          rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      gen3_halt_r  <= `RST_GEN3_HALT;
      gen2_halt_r  <= `RST_GEN2_HALT;
      gen01_halt_r <= `RST_GEN01_HALT;
      lock_clear_r <= `RST_LOCK_CLEAR;
      rdata_r      <= 8'h00;
    end
    else if (CE)
    begin
      gen3_halt_r  <= gen3_halt_nxt;
      gen2_halt_r  <= gen2_halt_nxt;
      gen01_halt_r <= gen01_halt_nxt;
      lock_clear_r <= lock_clear_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;

  // Output index: config 0..7, then precision 0..3
  // Assumes each output is fed from its own divider, as software must arrange
  assign codes[0]  = gen2_halt_r[1:0];
  assign codes[1]  = gen2_halt_r[3:2];
  assign codes[2]  = gen2_halt_r[5:4];
  assign codes[3]  = gen2_halt_r[7:6];
  assign codes[4]  = gen3_halt_r[1:0];
  assign codes[5]  = gen3_halt_r[3:2];
  assign codes[6]  = gen3_halt_r[5:4];
  assign codes[7]  = gen3_halt_r[7:6];
  assign codes[8]  = gen01_halt_r[1:0];
  assign codes[9]  = gen01_halt_r[3:2];
  assign codes[10] = gen01_halt_r[5:4];
  assign codes[11] = gen01_halt_r[7:6];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_gate
      halt_if hif ();
      assign hif.src  = DIV_SRC[gi];
      assign hif.code = codes[gi];
      assign outs[gi] = hif.out;
      clock_halt_gate u_gate (
        .clk (CLK_SYS),
        .rst (RST),
        .ce  (CE),
        .hif (hif)
      );
    end
  endgenerate

  assign CONFIG_OUTPUT    = outs[7:0];
  assign PRECISION_OUTPUT = outs[11:8];

  // Clear bits are levels: flag stays cleared until software drops the bit, except after a cycle with LOCK_LOST high
  lock_loss_flags #(
    .NUM_GEN (NUM_GEN)
  ) u_flags (
    .clk   (CLK_SYS),
    .rst   (RST),
    .ce    (CE),
    .lost  (LOCK_LOST),
    .clr   (lock_clear_r[NUM_GEN-1:0]),
    .flags (lock_flags)
  );

  write_gen3_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_WR && REG_ADDR == `OFS_GEN3_HALT)
      |=> (gen3_halt_r == $past(REG_WDATA)))
    else $error("Gen3 halt write lost");

  write_gen2_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_WR && REG_ADDR == `OFS_GEN2_HALT)
      |=> (gen2_halt_r == $past(REG_WDATA)))
    else $error("Gen2 halt write lost");

  status_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_ADDR == `OFS_LOCK_STATUS)
      |=> (REG_RDATA == {4'h0, $past(lock_flags)}))
    else $error("Status readback wrong");

  halt_out_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && gen01_halt_r[1:0] == `HALT_CODE_LOW && DIV_SRC[8]) ##1
    (CE && gen01_halt_r[1:0] == `HALT_CODE_LOW && !DIV_SRC[8])
      |=> !PRECISION_OUTPUT[0] [*2])
    else $error("Precision output 0 not held low");

  write_gen01_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_WR && REG_ADDR == `OFS_GEN01_HALT)
      |=> (gen01_halt_r == $past(REG_WDATA)))
    else $error("Gen0/1 halt write lost");

  write_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_WR && REG_ADDR == `OFS_LOCK_CLEAR)
      |=> (lock_clear_r == $past(REG_WDATA)))
    else $error("Clear register write lost");

  // Status and unmapped offsets must leave every control register alone
  write_refused_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_WR && !(REG_ADDR inside {`OFS_GEN3_HALT, `OFS_GEN2_HALT,
                                        `OFS_GEN01_HALT, `OFS_LOCK_CLEAR}))
      |=> $stable({gen3_halt_r, gen2_halt_r, gen01_halt_r, lock_clear_r}))
    else $error("Refused write changed a register");

  halt_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && !REG_WR)
      |=> $stable({gen3_halt_r, gen2_halt_r, gen01_halt_r}))
    else $error("Halt register moved without a write");

  clear_level_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && !(REG_WR && REG_ADDR == `OFS_LOCK_CLEAR))
      |=> $stable(lock_clear_r))
    else $error("Clear bits moved without a write");

  read_gen3_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_ADDR == `OFS_GEN3_HALT) |=> (REG_RDATA == $past(gen3_halt_r)))
    else $error("Gen3 halt readback wrong");

  read_gen2_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_ADDR == `OFS_GEN2_HALT) |=> (REG_RDATA == $past(gen2_halt_r)))
    else $error("Gen2 halt readback wrong");

  read_gen01_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_ADDR == `OFS_GEN01_HALT) |=> (REG_RDATA == $past(gen01_halt_r)))
    else $error("Gen0/1 halt readback wrong");

  read_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_ADDR == `OFS_LOCK_CLEAR) |=> (REG_RDATA == $past(lock_clear_r)))
    else $error("Clear register readback wrong");

  read_unmapped_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && !(REG_ADDR inside {`OFS_GEN3_HALT, `OFS_GEN2_HALT, `OFS_GEN01_HALT,
                              `OFS_LOCK_STATUS, `OFS_LOCK_CLEAR}))
      |=> (REG_RDATA == 8'h00))
    else $error("Unmapped offset read nonzero");

  // A frozen block must not move a pin, or a short pulse could escape
  freeze_out_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CE |=> ($stable(CONFIG_OUTPUT) && $stable(PRECISION_OUTPUT) && $stable(REG_RDATA)))
    else $error("Outputs moved while clock enable low");

  freeze_flags_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CE |=> $stable(lock_flags))
    else $error("Lock flags moved while clock enable low");

  reset_regs_a: assert property (@(posedge CLK_SYS)
    $fell(RST) |-> (gen3_halt_r == `RST_GEN3_HALT && gen2_halt_r == `RST_GEN2_HALT
                    && gen01_halt_r == `RST_GEN01_HALT && lock_clear_r == `RST_LOCK_CLEAR
                    && outs == '0))
    else $error("Registers not at reset values after reset");

  // Per synthesizer flag checks
  genvar fi;
  generate
    for (fi = 0; fi < NUM_GEN; fi++)
    begin : g_flag_chk
      flag_set_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (CE && LOCK_LOST[fi]) |=> lock_flags[fi])
        else $error("Lock loss flag not set");

      flag_clr_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (CE && lock_clear_r[fi] && !LOCK_LOST[fi]) |=> !lock_flags[fi])
        else $error("Lock loss flag not cleared");

      flag_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (lock_flags[fi] && !(CE && lock_clear_r[fi])) |=> lock_flags[fi])
        else $error("Lock loss flag dropped without clear");
    end
  endgenerate

  // Per pin checks; the code must have stood a cycle, else a rejoin may be in flight
  genvar oi;
  generate
    for (oi = 0; oi < NUM_OUT; oi++)
    begin : g_out_chk
      pin_low_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (CE && $past(CE) && codes[oi] == `HALT_CODE_LOW
          && $past(codes[oi]) == `HALT_CODE_LOW && $past(DIV_SRC[oi]) && !DIV_SRC[oi])
          |=> (!outs[oi]) [*2])
        else $error("Output not stopped low on falling edge");

      pin_high_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (CE && $past(CE) && codes[oi] == `HALT_CODE_HIGH
          && $past(codes[oi]) == `HALT_CODE_HIGH && !$past(DIV_SRC[oi]) && DIV_SRC[oi])
          |=> (outs[oi]) [*2])
        else $error("Output not stopped high on rising edge");

      pin_rise_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(outs[oi]) |-> $past(DIV_SRC[oi]))
        else $error("Output rose without a high source");

      pin_fall_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(outs[oi]) |-> !$past(DIV_SRC[oi]))
        else $error("Output fell without a low source");
    end
  endgenerate

  clear_c: cover property (@(posedge CLK_SYS) disable iff (RST)
    (CE && REG_WR && REG_ADDR == `OFS_LOCK_CLEAR && REG_WDATA != 8'h00));
  halt_c: cover property (@(posedge CLK_SYS) disable iff (RST)
    (gen3_halt_r[3:2] == `HALT_CODE_HIGH) ##4 CONFIG_OUTPUT[5]);

endmodule

`default_nettype wire

// ### hw/clock_halt_defs.svh
`ifndef CLOCK_HALT_DEFS_SVH
`define CLOCK_HALT_DEFS_SVH

// Register offsets
`define OFS_GEN3_HALT      8'hB6
`define OFS_GEN2_HALT      8'hB7
`define OFS_GEN01_HALT     8'hB8
`define OFS_LOCK_STATUS    8'hB9
`define OFS_LOCK_CLEAR     8'hBA

// Reset values
`define RST_GEN3_HALT      8'h00
`define RST_GEN2_HALT      8'h00
`define RST_GEN01_HALT     8'h00
`define RST_LOCK_CLEAR     8'h00
`define RST_LOCK_FLAGS     4'hF

// Field positions: field n of a halt register sits at bits 2n+1:2n
`define HALT_FIELD_W       2
`define HALT_FIELDS_PER_REG 4

// Halt codes
`define HALT_CODE_LOW      2'h2
`define HALT_CODE_HIGH     2'h3

// Flag field of the status register
`define LOCK_FLAG_LSB      0
`define LOCK_FLAG_W        4

`endif

// ### hw/clock_halt_pkg.sv
package clock_halt_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT_LOW,
    ST_HALT_HIGH
  } halt_state_type;

  typedef logic [1:0] halt_code_type;

endpackage

// ### hw/halt_if.sv
`timescale 1ns/1ps
`default_nettype none

interface halt_if;
  import clock_halt_pkg::*;
  logic          src;
  halt_code_type code;
  logic          out;

  modport gate (input src, input code, output out);
  modport ctrl (output src, output code, input out);
endinterface

`default_nettype wire

// ### hw/clock_halt_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_halt_defs.svh"

module clock_halt_gate
  import clock_halt_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  halt_if.gate      hif
);

  halt_state_type st_r;
  halt_state_type st_nxt;
  logic           src_r;
  logic           out_r;
  logic           out_nxt;

  // Stop only on the matching source edge, so the last pulse is always full width
  always_comb
  begin
    st_nxt  = st_r;
    out_nxt = out_r;
    unique case (st_r)
      ST_RUN:
      begin
        out_nxt = hif.src;
        if (hif.code == `HALT_CODE_LOW && src_r && !hif.src)
        begin
          st_nxt = ST_HALT_LOW;
        end
        else if (hif.code == `HALT_CODE_HIGH && !src_r && hif.src)
        begin
          st_nxt = ST_HALT_HIGH;
        end
      end
      ST_HALT_LOW:
      begin
        out_nxt = 1'b0;
        // Rejoin only while source sits at the held level
        if (hif.code != `HALT_CODE_LOW && !hif.src)
        begin
          st_nxt = ST_RUN;
        end
      end
      ST_HALT_HIGH:
      begin
        out_nxt = 1'b1;
        if (hif.code != `HALT_CODE_HIGH && hif.src)
        begin
          st_nxt = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r  <= ST_RUN;
      src_r <= 1'b0;
      out_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r  <= st_nxt;
      src_r <= hif.src;
      out_r <= out_nxt;
    end
  end

  assign hif.out = out_r;

  stop_low_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_r == ST_RUN && hif.code == `HALT_CODE_LOW && src_r && !hif.src)
      |=> (!out_r && st_r == ST_HALT_LOW))
    else $error("Halt low not entered on falling edge");

  stop_high_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_r == ST_RUN && hif.code == `HALT_CODE_HIGH && !src_r && hif.src)
      |=> (out_r && st_r == ST_HALT_HIGH))
    else $error("Halt high not entered on rising edge");

  held_low_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_HALT_LOW && hif.code == `HALT_CODE_LOW) [*2] |-> !out_r)
    else $error("Halted output not low");

  held_high_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_HALT_HIGH && hif.code == `HALT_CODE_HIGH) [*2] |-> out_r)
    else $error("Halted output not high");

  run_follow_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_r == ST_RUN && !hif.code[1]) |=> (out_r == $past(hif.src)))
    else $error("Running output does not follow source");

  rise_source_a: assert property (@(posedge clk) disable iff (rst)
    $rose(out_r) |-> $past(hif.src))
    else $error("Output rose without a high source");

  halt_low_c: cover property (@(posedge clk) disable iff (rst)
    st_r == ST_HALT_LOW ##1 st_r == ST_RUN);
  halt_high_c: cover property (@(posedge clk) disable iff (rst)
    st_r == ST_HALT_HIGH ##1 st_r == ST_RUN);

endmodule

`default_nettype wire

// ### hw/lock_loss_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_halt_defs.svh"

module lock_loss_flags #(
  parameter int NUM_GEN = 4
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic [NUM_GEN-1:0] lost,
  input  wire logic [NUM_GEN-1:0] clr,
  output logic      [NUM_GEN-1:0] flags
);

  generate
    if (NUM_GEN < 1 || NUM_GEN > `LOCK_FLAG_W)
    begin : g_bad
      $error("NUM_GEN out of range");
    end
  endgenerate

  logic [NUM_GEN-1:0] flag_r;
  logic [NUM_GEN-1:0] flag_nxt;

  // Set beats clear, so a loss during a held clear is still seen
  always_comb
  begin
    flag_nxt = lost | (flag_r & ~clr);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flag_r <= NUM_GEN'(`RST_LOCK_FLAGS);
    end
    else if (ce)
    begin
      flag_r <= flag_nxt;
    end
  end

  assign flags = flag_r;

  set_wins_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> ((flag_r & $past(lost)) == $past(lost)))
    else $error("Lock loss not captured");

  clear_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> ((flag_r & $past(clr) & ~$past(lost)) == '0))
    else $error("Flag not cleared");

  clear_top_a: assert property (@(posedge clk) disable iff (rst)
    (ce && clr[NUM_GEN-1] && !lost[NUM_GEN-1]) ##1 (ce && clr[NUM_GEN-1])
      |-> !flag_r[NUM_GEN-1])
    else $error("Top flag not cleared");

  sticky_a: assert property (@(posedge clk) disable iff (rst)
    (ce && (clr == '0)) |=> ((flag_r & $past(flag_r)) == $past(flag_r)))
    else $error("Flag dropped without clear");

  reset_set_a: assert property (@(posedge clk)
    $fell(rst) |-> (flag_r == NUM_GEN'(`RST_LOCK_FLAGS)))
    else $error("Flags not set by reset");

  lost_c: cover property (@(posedge clk) disable iff (rst)
    (flag_r == '0) ##1 (flag_r != '0));

endmodule

`default_nettype wire

// ### bench/output_clock_halt_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module output_clock_halt_tb_top;
  logic        CLK_SYS = 1'b0;
  logic        RST = 1'b1;
  logic        CE = 1'b0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [7:0]  REG_WDATA = 8'h00;
  logic        REG_WR = 1'b0;
  logic [11:0] DIV_SRC = 12'h000;
  logic [3:0]  LOCK_LOST = 4'h0;
  logic [7:0]  REG_RDATA;
  logic [7:0]  CONFIG_OUTPUT;
  logic [3:0]  PRECISION_OUTPUT;
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;
  bit          lk_en = 1'b0;
  bit          rnd_wr = 1'b0;
  bit          rnd_ce = 1'b0;
  logic [3:0]  lk_force = 4'h0;
  logic [7:0]  m_reg [4];
  logic [3:0]  m_flag;
  logic [11:0] m_prev;
  logic [11:0] m_out;
  int          m_st [12];
  logic [7:0]  m_rd;
  logic [1:0]  code;
  logic [7:0]  adr_tab [7] = '{8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hB5, 8'hBB};

  always #2.5 CLK_SYS = ~CLK_SYS;

  output_clock_halt u_dut (
    .CLK_SYS          (CLK_SYS),
    .RST              (RST),
    .CE               (CE),
    .REG_ADDR         (REG_ADDR),
    .REG_WDATA        (REG_WDATA),
    .REG_WR           (REG_WR),
    .REG_RDATA        (REG_RDATA),
    .DIV_SRC          (DIV_SRC),
    .LOCK_LOST        (LOCK_LOST),
    .CONFIG_OUTPUT    (CONFIG_OUTPUT),
    .PRECISION_OUTPUT (PRECISION_OUTPUT)
  );

  // Model register map: 0 gen2 halt, 1 gen3 halt, 2 gen0/1 halt, 3 clear
  function automatic logic [7:0] rd_of(input logic [7:0] a);
    case (a)
      8'hB7: return m_reg[0];
      8'hB6: return m_reg[1];
      8'hB8: return m_reg[2];
      8'hBA: return m_reg[3];
      8'hB9: return {4'h0, m_flag};
      default: return 8'h00;
    endcase
  endfunction

  // Model works on pre-edge state, so writes land one edge later
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      m_reg = '{default: 8'h00};
      m_flag = 4'hF;
      m_prev = 12'h000;
      m_out = 12'h000;
      m_st = '{default: 0};
      m_rd = 8'h00;
    end
    else if (CE)
    begin
      m_rd = rd_of(REG_ADDR);
      for (int i = 0; i < 12; i++)
      begin
        code = m_reg[i / 4][2 * (i % 4) +: 2];
        if (m_st[i] == 0)
        begin
          m_out[i] = DIV_SRC[i];
          if (code == 2'h2 && m_prev[i] && !DIV_SRC[i])
            m_st[i] = 1;
          else if (code == 2'h3 && !m_prev[i] && DIV_SRC[i])
            m_st[i] = 2;
        end
        else if (code != 2'(m_st[i] + 1) && DIV_SRC[i] == (m_st[i] == 2))
          m_st[i] = 0;
        m_prev[i] = DIV_SRC[i];
      end
      m_flag = LOCK_LOST | (m_flag & ~m_reg[3][3:0]);
      if (REG_WR)
        case (REG_ADDR)
          8'hB7: m_reg[0] = REG_WDATA;
          8'hB6: m_reg[1] = REG_WDATA;
          8'hB8: m_reg[2] = REG_WDATA;
          8'hBA: m_reg[3] = REG_WDATA;
          default: ;
        endcase
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  always @(negedge CLK_SYS)
  begin
    chk(CONFIG_OUTPUT, m_out[7:0], "config");
    chk({4'h0, PRECISION_OUTPUT}, {4'h0, m_out[11:8]}, "precision");
    chk(REG_RDATA, m_rd, "rdata");
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Generous ceiling; the planned run is under 8000 cycles
  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      $display("BAD t=%0t run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic step(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic ce);
    @(negedge CLK_SYS);
    DIV_SRC = DIV_SRC ^ (12'($urandom) & 12'($urandom));
    LOCK_LOST = lk_force | (4'($urandom) & 4'($urandom) & 4'($urandom) & {4{lk_en}});
    CE = ce;
    REG_WR = wr;
    REG_ADDR = a;
    REG_WDATA = d;
  endtask

  task automatic cyc(input int n);
    repeat (n)
      step(rnd_wr && ($urandom % 4 == 0), adr_tab[$urandom % 7], 8'($urandom),
           !rnd_ce || ($urandom % 6 != 0));
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1'b1, a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    step(1'b0, a, 8'h00, 1'b1);
    @(negedge CLK_SYS);
    chk(REG_RDATA, exp, "read");
  endtask

  initial
  begin
    void'($urandom(47033));
    repeat (10) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RST = 1'b0;
    wr(8'hB9, 8'h00);
    wr(8'hBB, 8'hFF);
    rd(8'hB9, 8'h0F);
    rd(8'hBB, 8'h00);
    // Code 4 wraps to 0, so the last pass checks restart from held levels
    for (int c = 0; c < 5; c++)
    begin
      wr(8'hB7, {4{2'(c)}});
      wr(8'hB6, {4{2'(c)}});
      wr(8'hB8, {4{2'(c)}});
      cyc(40);
    end
    wr(8'hBA, 8'h0F);
    cyc(3);
    rd(8'hB9, 8'h00);
    wr(8'hBA, 8'h00);
    lk_force = 4'h4;
    cyc(1);
    lk_force = 4'h0;
    rd(8'hB9, 8'h04);
    lk_en = 1'b1;
    rnd_wr = 1'b1;
    rnd_ce = 1'b1;
    cyc(6000);
    lk_en = 1'b0;
    rnd_wr = 1'b0;
    rnd_ce = 1'b0;
    // Quiet the bus first, so no stale random write lands at the release edge
    step(1'b0, 8'h00, 8'h00, 1'b1);
    RST <= 1'b1;
    repeat (3) @(negedge CLK_SYS);
    RST = 1'b0;
    rd(8'hB9, 8'h0F);
    rd(8'hB6, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
